// >>> src/pci_power_mgmt_regs.sv
// Power management capability and control/status registers of one switch port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Sticky writable 3-bit aux current in 24:22, reset 7 (375 mA).
// - Capability bits 25 and 26 read zero, no D1 or D2.
// - Sticky 5-bit event support mask 31:27, reset 11001.
// - Read-write power state in 1:0, reset D0; 3 means D3hot.
// - Lockable context-preserved bit 3, default one.
// - Sticky writable event enable bit 8, reset zero.
// - Hot reset leaves event enable alone; fundamental reset restores it.
// - Port-made event sets sticky status bit 15; writing one clears.
// - Forwarded downstream events do not set the status bit.
// - Upstream port never sets the status bit.
// - Data select, scale and data fields read zero.
// - Bits 22 and 23 of control/status read zero.
module pci_power_mgmt_regs (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        HOT_RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic        PORT_EVENT,
  input  wire logic        FWD_EVENT,
  output logic      [31:0] RDATA,
  output logic      [1:0]  POWER_STATE,
  output logic             EVENT_MSG_EN,
  output logic             IS_UPSTREAM
);

  logic [2:0] aux_current_req_r;
  logic [4:0] evsup_r;
  logic [1:0] power_state_sel_r;
  logic       context_preserved_flag_r;
  logic       power_event_enable_r;
  logic       power_event_status_r;
  logic       upstream_r;
  logic       lock_r;
  logic [31:0] cap_word;
  logic [31:0] csr_word;
  logic [31:0] cfg_word;
  logic [31:0] rdata_nxt;
  logic [1:0] wr_state;
  logic       wr_cap;
  logic       wr_csr;
  logic       wr_cfg;
  logic       ev_set;

  assign wr_cap   = WR && (ADDR == pm_regs_pkg::OFFS_CAP);
  assign wr_csr   = WR && (ADDR == pm_regs_pkg::OFFS_CSR);
  assign wr_cfg   = WR && (ADDR == pm_regs_pkg::OFFS_PORT_CFG);
  assign wr_state = WDATA[pm_regs_pkg::POWER_STATE_SEL_MSB:pm_regs_pkg::POWER_STATE_SEL_LSB];
  assign ev_set   = PORT_EVENT && !upstream_r;

  // Sticky capability fields, fundamental reset only
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      aux_current_req_r <= pm_regs_pkg::AUX_RST;
      evsup_r           <= pm_regs_pkg::EVSUP_RST;
    end else if (wr_cap) begin
      aux_current_req_r <= WDATA[pm_regs_pkg::AUX_MSB:pm_regs_pkg::AUX_LSB];
      evsup_r           <= WDATA[pm_regs_pkg::EVSUP_MSB:pm_regs_pkg::EVSUP_LSB];
    end
  end

  // Power state, returned to D0 by either reset
  always_ff @(posedge CLK) begin
    if (SYS_RST || HOT_RST) begin
      power_state_sel_r <= pm_regs_pkg::POWER_STATE_SEL_D0;
    end else if (wr_csr && wr_state != pm_regs_pkg::POWER_STATE_SEL_D1
                 && wr_state != pm_regs_pkg::POWER_STATE_SEL_D2) begin
      power_state_sel_r <= wr_state;
    end
  end

  // Context flag is writable until the port lock bit is set
  always_ff @(posedge CLK) begin
    if (SYS_RST || HOT_RST) begin
      context_preserved_flag_r <= pm_regs_pkg::CTX_RST;
    end else if (wr_csr && !lock_r) begin
      context_preserved_flag_r <= WDATA[pm_regs_pkg::CTX_BIT];
    end
  end

  // Event enable survives a hot reset
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      power_event_enable_r <= pm_regs_pkg::EVEN_RST;
    end else if (wr_csr) begin
      power_event_enable_r <= WDATA[pm_regs_pkg::EVEN_BIT];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      power_event_status_r <= 1'b0;
    end else if (ev_set) begin
      power_event_status_r <= 1'b1;
    end else if (wr_csr && WDATA[pm_regs_pkg::EVST_BIT]) begin
      power_event_status_r <= 1'b0;
    end
  end

  // Port configuration: upstream role and lock
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      upstream_r <= 1'b0;
      lock_r     <= 1'b0;
    end else if (wr_cfg) begin
      upstream_r <= WDATA[pm_regs_pkg::UPSTREAM_BIT];
      lock_r     <= WDATA[pm_regs_pkg::LOCK_BIT];
    end
  end

  always_comb begin
    cap_word = pm_regs_pkg::ZERO_WORD;
    cap_word[pm_regs_pkg::AUX_MSB:pm_regs_pkg::AUX_LSB]     = aux_current_req_r;
    cap_word[pm_regs_pkg::EVSUP_MSB:pm_regs_pkg::EVSUP_LSB] = evsup_r;
    csr_word = pm_regs_pkg::ZERO_WORD;
    csr_word[pm_regs_pkg::POWER_STATE_SEL_MSB:pm_regs_pkg::POWER_STATE_SEL_LSB] = power_state_sel_r;
    csr_word[pm_regs_pkg::CTX_BIT]  = context_preserved_flag_r;
    csr_word[pm_regs_pkg::EVEN_BIT] = power_event_enable_r;
    csr_word[pm_regs_pkg::EVST_BIT] = power_event_status_r;
    cfg_word = pm_regs_pkg::ZERO_WORD;
    cfg_word[pm_regs_pkg::UPSTREAM_BIT] = upstream_r;
    cfg_word[pm_regs_pkg::LOCK_BIT]     = lock_r;
    case (ADDR)
      pm_regs_pkg::OFFS_CAP:      rdata_nxt = cap_word;
      pm_regs_pkg::OFFS_CSR:      rdata_nxt = csr_word;
      pm_regs_pkg::OFFS_PORT_CFG: rdata_nxt = cfg_word;
      default:                    rdata_nxt = pm_regs_pkg::ZERO_WORD;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= pm_regs_pkg::ZERO_WORD;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end else begin
      RDATA <= pm_regs_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      POWER_STATE  <= pm_regs_pkg::POWER_STATE_SEL_D0;
      EVENT_MSG_EN <= 1'b0;
      IS_UPSTREAM  <= 1'b0;
    end else begin
      POWER_STATE  <= power_state_sel_r;
      EVENT_MSG_EN <= power_event_enable_r;
      IS_UPSTREAM  <= upstream_r;
    end
  end

  property p_aux_reset;
    @(posedge CLK) SYS_RST |=> aux_current_req_r == pm_regs_pkg::AUX_RST;
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("aux current reset wrong");

  property p_cap_zero;
    @(posedge CLK) disable iff (SYS_RST)
      RD && ADDR == pm_regs_pkg::OFFS_CAP
      |=> RDATA[pm_regs_pkg::D2_BIT:pm_regs_pkg::D1_BIT] == 2'h0;
  endproperty
  a_cap_zero: assert property (p_cap_zero) else $error("D1/D2 support not zero");

  property p_evsup_reset;
    @(posedge CLK) SYS_RST |=> evsup_r == pm_regs_pkg::EVSUP_RST;
  endproperty
  a_evsup_reset: assert property (p_evsup_reset) else $error("support mask reset wrong");

  property p_reserved_state;
    @(posedge CLK) disable iff (SYS_RST || HOT_RST)
      wr_csr && (wr_state == pm_regs_pkg::POWER_STATE_SEL_D1 || wr_state == pm_regs_pkg::POWER_STATE_SEL_D2)
      |=> $stable(power_state_sel_r);
  endproperty
  a_reserved_state: assert property (p_reserved_state) else $error("reserved state taken");

  sequence s_d3_write;
    wr_csr && wr_state == pm_regs_pkg::POWER_STATE_SEL_D3HOT ##1 !wr_csr;
  endsequence
  property p_state_write;
    @(posedge CLK) disable iff (SYS_RST || HOT_RST)
      s_d3_write |=> POWER_STATE == pm_regs_pkg::POWER_STATE_SEL_D3HOT;
  endproperty
  a_state_write: assert property (p_state_write) else $error("D3hot write lost");

  property p_hot_keeps_enable;
    @(posedge CLK) disable iff (SYS_RST) HOT_RST && !wr_csr |=> $stable(power_event_enable_r);
  endproperty
  a_hot_keeps_enable: assert property (p_hot_keeps_enable) else $error("enable moved");

  // An event sets status even when a clear lands in the same cycle
  sequence s_event;
    PORT_EVENT && !upstream_r;
  endsequence
  property p_status_set;
    @(posedge CLK) disable iff (SYS_RST) s_event |=> power_event_status_r;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set");

  property p_no_fwd_set;
    @(posedge CLK) disable iff (SYS_RST)
      !power_event_status_r && !(PORT_EVENT && !upstream_r) |=> !power_event_status_r;
  endproperty
  a_no_fwd_set: assert property (p_no_fwd_set) else $error("status set without event");

  property p_read_zero;
    @(posedge CLK) disable iff (SYS_RST)
      RD && ADDR == pm_regs_pkg::OFFS_CSR |=> RDATA[31:16] == 16'h0000 && RDATA[14:9] == 6'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unused field not zero");

  // Reset values of the control/status fields
  property p_state_reset;
    @(posedge CLK) SYS_RST |=> power_state_sel_r == pm_regs_pkg::POWER_STATE_SEL_D0;
  endproperty
  a_state_reset: assert property (p_state_reset) else $error("power state reset wrong");

  property p_ctx_reset;
    @(posedge CLK) SYS_RST |=> context_preserved_flag_r == pm_regs_pkg::CTX_RST;
  endproperty
  a_ctx_reset: assert property (p_ctx_reset) else $error("context flag reset wrong");

  property p_enable_reset;
    @(posedge CLK) SYS_RST |=> power_event_enable_r == pm_regs_pkg::EVEN_RST;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable reset wrong");

  property p_status_reset;
    @(posedge CLK) SYS_RST |=> !power_event_status_r;
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status reset wrong");

  // Hot reset returns the power state to D0 and restores the context flag
  property p_hot_state;
    @(posedge CLK) disable iff (SYS_RST)
      HOT_RST |=> power_state_sel_r == pm_regs_pkg::POWER_STATE_SEL_D0
                  && context_preserved_flag_r == pm_regs_pkg::CTX_RST;
  endproperty
  a_hot_state: assert property (p_hot_state) else $error("hot reset state wrong");

  // Status is sticky: a hot reset alone never moves it
  property p_hot_keeps_status;
    @(posedge CLK) disable iff (SYS_RST)
      HOT_RST && !wr_csr && !PORT_EVENT |=> $stable(power_event_status_r);
  endproperty
  a_hot_keeps_status: assert property (p_hot_keeps_status) else $error("status moved");

  // The state register never holds a reserved code
  property p_state_legal;
    @(posedge CLK) disable iff (SYS_RST)
      power_state_sel_r != pm_regs_pkg::POWER_STATE_SEL_D1
      && power_state_sel_r != pm_regs_pkg::POWER_STATE_SEL_D2;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("reserved state held");

  // Enable follows bit 8 of every control/status write
  property p_enable_write;
    @(posedge CLK) disable iff (SYS_RST)
      wr_csr |=> power_event_enable_r == $past(WDATA[pm_regs_pkg::EVEN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  // A locked context flag ignores writes
  property p_ctx_locked;
    @(posedge CLK) disable iff (SYS_RST || HOT_RST)
      wr_csr && lock_r |=> $stable(context_preserved_flag_r);
  endproperty
  a_ctx_locked: assert property (p_ctx_locked) else $error("locked flag written");

  // A clear with no competing event empties the status bit
  sequence s_clear;
    wr_csr && WDATA[pm_regs_pkg::EVST_BIT] && !(PORT_EVENT && !upstream_r);
  endsequence
  property p_status_clear;
    @(posedge CLK) disable iff (SYS_RST) s_clear |=> !power_event_status_r;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  // A forwarded event alone leaves the status bit clear
  property p_fwd_only;
    @(posedge CLK) disable iff (SYS_RST)
      FWD_EVENT && !PORT_EVENT && !power_event_status_r |=> !power_event_status_r;
  endproperty
  a_fwd_only: assert property (p_fwd_only) else $error("forwarded event set status");

  // An upstream port never raises status
  property p_upstream_quiet;
    @(posedge CLK) disable iff (SYS_RST)
      upstream_r && !power_event_status_r |=> !power_event_status_r;
  endproperty
  a_upstream_quiet: assert property (p_upstream_quiet) else $error("upstream status set");

  // Output copies trail their registers by one cycle
  property p_state_out;
    @(posedge CLK) disable iff (SYS_RST)
      !SYS_RST |=> POWER_STATE == $past(power_state_sel_r);
  endproperty
  a_state_out: assert property (p_state_out) else $error("state output stale");

  property p_enable_out;
    @(posedge CLK) disable iff (SYS_RST)
      !SYS_RST |=> EVENT_MSG_EN == $past(power_event_enable_r);
  endproperty
  a_enable_out: assert property (p_enable_out) else $error("enable output stale");

  // Read data stands one cycle and then returns to zero
  property p_rdata_idle;
    @(posedge CLK) disable iff (SYS_RST) !RD |=> RDATA == pm_regs_pkg::ZERO_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  // Capability writes land in both writable fields
  property p_cap_write;
    @(posedge CLK) disable iff (SYS_RST)
      wr_cap |=> aux_current_req_r == $past(WDATA[pm_regs_pkg::AUX_MSB:pm_regs_pkg::AUX_LSB])
                 && evsup_r == $past(WDATA[pm_regs_pkg::EVSUP_MSB:pm_regs_pkg::EVSUP_LSB]);
  endproperty
  a_cap_write: assert property (p_cap_write) else $error("capability write lost");

endmodule : pci_power_mgmt_regs
`default_nettype wire

// >>> src/pm_regs_pkg.sv
// Package: register map, field layout and reset values of the power management registers
package pm_regs_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFFS_CAP        = 8'hC0;
  localparam logic [7:0]  OFFS_CSR        = 8'hC4;
  localparam logic [7:0]  OFFS_PORT_CFG   = 8'hE0;
  localparam int          AUX_LSB         = 22;
  localparam int          AUX_MSB         = 24;
  localparam int          D1_BIT          = 25;
  localparam int          D2_BIT          = 26;
  localparam int          EVSUP_LSB       = 27;
  localparam int          EVSUP_MSB       = 31;
  localparam int          POWER_STATE_SEL_LSB      = 0;
  localparam int          POWER_STATE_SEL_MSB      = 1;
  localparam int          CTX_BIT         = 3;
  localparam int          EVEN_BIT        = 8;
  localparam int          EVST_BIT        = 15;
  localparam int          UPSTREAM_BIT    = 0;
  localparam int          LOCK_BIT        = 1;
  localparam logic [2:0]  AUX_RST         = 3'h7;
  localparam logic [4:0]  EVSUP_RST       = 5'h19;
  localparam logic [1:0]  POWER_STATE_SEL_D0       = 2'h0;
  localparam logic [1:0]  POWER_STATE_SEL_D1       = 2'h1;
  localparam logic [1:0]  POWER_STATE_SEL_D2       = 2'h2;
  localparam logic [1:0]  POWER_STATE_SEL_D3HOT    = 2'h3;
  localparam logic        CTX_RST         = 1'h1;
  localparam logic        EVEN_RST        = 1'h0;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
endpackage : pm_regs_pkg

// >>> sim/tb_top.sv
// Testbench: register access sequences for the power management register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        HOT_RST = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        PORT_EVENT = 1'b0;
  logic        FWD_EVENT = 1'b0;
  logic [31:0] RDATA;
  logic [1:0]  POWER_STATE;
  logic        EVENT_MSG_EN;
  logic        IS_UPSTREAM;
  int          n_fail = 0;
  int          check_count = 0;

  always #12.5 CLK = ~CLK;

  pci_power_mgmt_regs u_dut (
    .CLK          (CLK),
    .SYS_RST      (SYS_RST),
    .HOT_RST      (HOT_RST),
    .ADDR         (ADDR),
    .WDATA        (WDATA),
    .WR           (WR),
    .RD           (RD),
    .PORT_EVENT   (PORT_EVENT),
    .FWD_EVENT    (FWD_EVENT),
    .RDATA        (RDATA),
    .POWER_STATE  (POWER_STATE),
    .EVENT_MSG_EN (EVENT_MSG_EN),
    .IS_UPSTREAM  (IS_UPSTREAM)
  );

  task automatic complete_run;
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask : rd

  // One-cycle pulse on the event inputs
  task automatic ev(input logic p, input logic f);
    @(posedge CLK);
    PORT_EVENT <= p;
    FWD_EVENT  <= f;
    @(posedge CLK);
    PORT_EVENT <= 1'b0;
    FWD_EVENT  <= 1'b0;
  endtask : ev

  task automatic pulse_rst(input logic hot);
    @(posedge CLK);
    if (hot) HOT_RST <= 1'b1;
    else SYS_RST <= 1'b1;
    @(posedge CLK);
    HOT_RST <= 1'b0;
    SYS_RST <= 1'b0;
  endtask : pulse_rst

  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(8'hC4, 32'h0000_0008);
    rd(8'hC0, 32'hC9C0_0000);
    rd(8'h10, 32'h0000_0000);
    wr(8'hC4, 32'hFFFF_FFFF);
    rd(8'hC4, 32'h0000_010B);
    chk({29'h0, EVENT_MSG_EN, POWER_STATE}, 32'h0000_0007);
    wr(8'hC4, 32'h0000_0101);
    rd(8'hC4, 32'h0000_0103);
    wr(8'hC4, 32'h0000_0102);
    rd(8'hC4, 32'h0000_0103);
    ev(1'b0, 1'b1);
    rd(8'hC4, 32'h0000_0103);
    wr(8'hC4, 32'h0000_0003);
    ev(1'b1, 1'b0);
    rd(8'hC4, 32'h0000_8003);
    wr(8'hC4, 32'h0000_8103);
    rd(8'hC4, 32'h0000_0103);
    // Event and clear in one cycle: the event wins
    @(posedge CLK);
    PORT_EVENT <= 1'b1;
    wr(8'hC4, 32'h0000_8103);
    PORT_EVENT <= 1'b0;
    rd(8'hC4, 32'h0000_8103);
    wr(8'hC4, 32'h0000_8103);
    rd(8'hC4, 32'h0000_0103);
    wr(8'hE0, 32'h0000_0003);
    rd(8'hE0, 32'h0000_0003);
    chk({31'h0, IS_UPSTREAM}, 32'h0000_0001);
    ev(1'b1, 1'b0);
    rd(8'hC4, 32'h0000_0103);
    wr(8'hC4, 32'h0000_010B);
    rd(8'hC4, 32'h0000_0103);
    wr(8'hC0, 32'hFFFF_FFFF);
    rd(8'hC0, 32'hF9C0_0000);
    wr(8'hC0, 32'h0100_0000);
    pulse_rst(1'b1);
    rd(8'hC4, 32'h0000_0108);
    rd(8'hC0, 32'h0100_0000);
    rd(8'hE0, 32'h0000_0003);
    chk({30'h0, EVENT_MSG_EN, IS_UPSTREAM}, 32'h0000_0003);
    pulse_rst(1'b0);
    rd(8'hC4, 32'h0000_0008);
    rd(8'hC0, 32'hC9C0_0000);
    chk({29'h0, EVENT_MSG_EN, POWER_STATE}, 32'h0000_0000);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
